// ### src/ddrb_pkg.sv
package ddrb_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 36;
  localparam int CNT_W = 2;
  localparam int BURST_LEN = 4;
  localparam int FIFO_DEPTH = 16;
  localparam logic [2:0] BEAT_LAST = 3'h3;
  localparam logic [2:0] WR_BEATS = 3'h4;
  localparam logic [2:0] GAP_AFTER_WRITE = 3'h3;
  localparam logic [2:0] GAP_AFTER_READ = 3'h5;
  localparam logic [2:0] RD_CAP_START = 3'h6;
  localparam logic [2:0] RD_CAP_FIRST = 3'h4;
  localparam logic [2:0] RD_CAP_LAST = 3'h1;
endpackage

// ### src/ddrb_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ddrb_link_if import ddrb_pkg::*; ();
  logic k_pos;
  logic c_pos;
  logic load_strobe_n;
  logic rd_wr_sel;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dq_ctrl_out;
  logic dq_ctrl_oe;
  logic [DATA_W-1:0] dq_dev_out;
  logic dq_dev_oe;
  logic echo_clock;
  logic echo_clock_n;
  logic [DATA_W-1:0] dq_bus;
  assign dq_bus = dq_ctrl_oe ? dq_ctrl_out : (dq_dev_oe ? dq_dev_out : '0);
  modport device (
    input k_pos, c_pos, load_strobe_n, rd_wr_sel, addr, dq_bus,
    output dq_dev_out, dq_dev_oe, echo_clock, echo_clock_n
  );
  modport ctrl (
    output k_pos, c_pos, load_strobe_n, rd_wr_sel, addr, dq_ctrl_out, dq_ctrl_oe,
    input dq_bus, echo_clock, echo_clock_n
  );
endinterface
`default_nettype wire

// ### src/ddrb_device.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - address taken only on positive input phase
// - write words sampled every input-clock edge
// - read words launched on selected clock pair
// - each access moves exactly four words
// - burst counter loads from address bits 1:0
// - counter steps linearly, wrapping within four
// - controller pulls load strobe low to start
// - select high reads, low writes
// - data outputs released when not reading
// - address ignored unless load strobe selects
// - eighteen-bit address over 256K by 36 words
// - shared address pins, direction by select only
// - inputs and outputs pass through registers
// - writes self-timed, no write pulse needed
// - read data edge-aligned with echo clocks
// - echo clocks run continuously from selected pair
// - accesses start only on positive input phase
module ddrb_device import ddrb_pkg::*; #(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  // system
  input wire logic sys_clk,
  input wire logic sys_rst,
  // configuration
  input wire logic single_clock_mode,
  // link
  ddrb_link_if.device link
);
  typedef struct packed {
    logic act;
    logic rd;
    logic [AW-1:0] base;
    logic [CNT_W-1:0] beat;
    logic [DW-1:0] q;
    logic q_oe;
    logic echo;
  } ddrb_dev_t;

  ddrb_dev_t st, next_st;
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic wr_en;
  logic [AW-1:0] wr_addr;

  initial begin
    if (AW != ADDR_W || DW != DATA_W) $error("ddrb_device: unsupported geometry");
  end

  function automatic logic [AW-1:0] burst_addr(input logic [AW-1:0] base,
                                               input logic [CNT_W-1:0] beat);
    logic [CNT_W-1:0] lo;
    lo = base[CNT_W-1:0] + beat;
    return {base[AW-1:CNT_W], lo};
  endfunction

  always_comb begin
    next_st = st;
    wr_en = 1'b0;
    wr_addr = burst_addr(st.base, st.beat);
    // echo follows the same clock phase as the data launch
    next_st.echo = single_clock_mode ? link.k_pos : link.c_pos;
    next_st.q_oe = 1'b0;
    if (st.act) begin
      if (st.rd) begin
        next_st.q = mem[wr_addr];
        next_st.q_oe = 1'b1;
      end else begin
        wr_en = 1'b1;
      end
      next_st.beat = st.beat + 2'h1;
      if ({1'b0, st.beat} == BEAT_LAST) begin
        next_st.act = 1'b0;
      end
    end
    // a load on the last beat chains the next burst; earlier loads are dropped
    if ((!st.act || {1'b0, st.beat} == BEAT_LAST) &&
        link.k_pos && !link.load_strobe_n) begin
      next_st.act = 1'b1;
      next_st.rd = link.rd_wr_sel;
      next_st.base = link.addr;
      next_st.beat = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= link.dq_bus;
    end
  end

  assign link.dq_dev_out = st.q;
  assign link.dq_dev_oe = st.q_oe;
  assign link.echo_clock = st.echo;
  assign link.echo_clock_n = ~st.echo;
endmodule
`default_nettype wire

// ### src/ddrb_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module ddrb_fifo #(
  parameter int W = 36,
  parameter int D = 16
) (
  // system
  input wire logic sys_clk,
  input wire logic sys_rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(D):0] count
);
  localparam int PW = $clog2(D);
  typedef struct packed {
    logic [PW:0] wp;
    logic [PW:0] rp;
  } ddrb_fifo_t;
  ddrb_fifo_t st, next_st;
  logic [W-1:0] mem [0:D-1];
  logic push;
  logic pop;

  initial begin
    if (D < 2 || (1 << PW) != D) $error("ddrb_fifo: depth must be a power of two");
  end

  assign count = st.wp - st.rp;
  assign in_ready = (count != (PW+1)'(D));
  assign out_valid = (count != '0);
  assign out_data = mem[st.rp[PW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_st = st;
    if (push) next_st.wp = st.wp + 1'b1;
    if (pop) next_st.rp = st.rp + 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[st.wp[PW-1:0]] <= in_data;
    end
  end
endmodule

module ddrb_ctrl import ddrb_pkg::*; (
  // system
  input wire logic sys_clk,
  input wire logic sys_rst,
  // request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_read,
  input wire logic [ADDR_W-1:0] req_addr,
  // write data
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [DATA_W-1:0] wr_data,
  // read data
  output logic rd_valid,
  output logic [DATA_W-1:0] rd_data,
  // link
  ddrb_link_if.ctrl link
);
  typedef struct packed {
    logic pend;
    logic pend_rd;
    logic [ADDR_W-1:0] pend_addr;
    logic k;
    logic ld_n;
    logic rw;
    logic [ADDR_W-1:0] a;
    logic [2:0] gap;
    logic [2:0] wcnt;
    logic [2:0] rcnt;
    logic [DATA_W-1:0] dq;
    logic dq_oe;
    logic rv;
    logic [DATA_W-1:0] rd;
  } ddrb_ctrl_t;

  ddrb_ctrl_t st, next_st;
  logic f_valid;
  logic f_pop;
  logic [DATA_W-1:0] f_data;
  logic [$clog2(FIFO_DEPTH):0] f_count;
  logic issue;

  ddrb_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data),
    .count(f_count)
  );

  // a write waits until its whole burst is buffered, so the bus never starves
  // words still owed to the running burst are not free for the next one
  assign issue = st.pend && !st.k && (st.gap == '0) &&
                 (st.pend_rd || f_count >= ($clog2(FIFO_DEPTH)+1)'(BURST_LEN) +
                                ($clog2(FIFO_DEPTH)+1)'(st.wcnt));
  assign f_pop = (st.wcnt != '0);

  always_comb begin
    next_st = st;
    next_st.k = ~st.k;
    next_st.ld_n = 1'b1;
    next_st.dq_oe = 1'b0;
    next_st.rv = 1'b0;
    if (st.gap != '0) next_st.gap = st.gap - 3'h1;
    if (req_valid && !st.pend) begin
      next_st.pend = 1'b1;
      next_st.pend_rd = req_read;
      next_st.pend_addr = req_addr;
    end
    // counters step before a new issue reloads them, so back-to-back bursts chain
    if (st.wcnt != '0) begin
      next_st.wcnt = st.wcnt - 3'h1;
      next_st.dq = f_data;
      next_st.dq_oe = 1'b1;
    end
    if (st.rcnt != '0) begin
      next_st.rcnt = st.rcnt - 3'h1;
      if (st.rcnt <= RD_CAP_FIRST && st.rcnt >= RD_CAP_LAST) begin
        next_st.rv = 1'b1;
        next_st.rd = link.dq_bus;
      end
    end
    if (issue) begin
      next_st.pend = 1'b0;
      next_st.ld_n = 1'b0;
      next_st.rw = st.pend_rd;
      next_st.a = st.pend_addr;
      // reads hold off longer so the next write cannot meet the read tail
      next_st.gap = st.pend_rd ? GAP_AFTER_READ : GAP_AFTER_WRITE;
      if (st.pend_rd) next_st.rcnt = RD_CAP_START;
      else next_st.wcnt = WR_BEATS;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st <= '0;
      st.ld_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign req_ready = ~st.pend;
  assign rd_valid = st.rv;
  assign rd_data = st.rd;
  assign link.k_pos = st.k;
  assign link.c_pos = st.k;
  assign link.load_strobe_n = st.ld_n;
  assign link.rd_wr_sel = st.rw;
  assign link.addr = st.a;
  assign link.dq_ctrl_out = st.dq;
  assign link.dq_ctrl_oe = st.dq_oe;
endmodule
`default_nettype wire

// ### tb/ddrb_link_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ddrb_link_chk (
  // system
  input wire logic sys_clk,
  input wire logic sys_rst,
  // link
  input wire logic k_pos,
  input wire logic c_pos,
  input wire logic load_strobe_n,
  input wire logic rd_wr_sel,
  input wire logic dq_ctrl_oe,
  input wire logic dq_dev_oe,
  input wire logic echo_clock,
  input wire logic echo_clock_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence rd_ld;
    !load_strobe_n && rd_wr_sel;
  endsequence
  sequence wr_ld;
    !load_strobe_n && !rd_wr_sel;
  endsequence
  AST_LD_PHASE:
    assert property (!load_strobe_n |-> k_pos) else $error("load off phase");
  AST_PHASE_TGL:
    assert property (!$past(sys_rst) |-> k_pos != $past(k_pos)) else $error("phase stuck");
  AST_RD_BURST:
    assert property (rd_ld |-> ##2 dq_dev_oe [*4] ##1 !dq_dev_oe) else $error("read burst");
  AST_RD_QUIET:
    assert property (rd_ld |-> !dq_dev_oe ##1 !dq_dev_oe) else $error("early drive");
  AST_WR_BURST:
    assert property (wr_ld |=> dq_ctrl_oe [*4]) else $error("write burst");
  AST_RD_RELEASE:
    assert property (rd_ld |=> !dq_ctrl_oe [*5]) else $error("bus held in read");
  AST_NO_CLASH:
    assert property (!(dq_ctrl_oe && dq_dev_oe)) else $error("bus clash");
  AST_GAP_WR:
    assert property (wr_ld |=> load_strobe_n [*3]) else $error("write gap");
  AST_GAP_RD:
    assert property (rd_ld |=> load_strobe_n [*5]) else $error("read gap");
  AST_ECHO:
    assert property (!$past(sys_rst) |-> echo_clock == $past(c_pos) && echo_clock_n != echo_clock)
      else $error("echo clock");
endmodule
`default_nettype wire

// ### tb/ddr_burst4_sram_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module ddr_burst4_sram_port_test;
  import ddrb_pkg::*;
  logic sys_clk = 0;
  logic sys_rst = 1;
  logic single_clock_mode = 0;
  logic req_valid = 0, req_read = 0, wr_valid = 0, req_ready, wr_ready, rd_valid;
  logic [ADDR_W-1:0] req_addr = '0, base, a;
  logic [DATA_W-1:0] wr_data = '0, rd_data;
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] exp_q [$];
  logic [ADDR_W:0] ld_q [$];
  int mismatches = 0, samples_checked = 0;
  ddrb_link_if link ();
  ddrb_device u_ddrb_device (.sys_clk, .sys_rst, .single_clock_mode, .link(link));
  ddrb_ctrl u_ddrb_ctrl (.sys_clk, .sys_rst, .req_valid, .req_ready, .req_read, .req_addr,
    .wr_valid, .wr_ready, .wr_data, .rd_valid, .rd_data, .link(link));
  ddrb_link_chk u_chk (.sys_clk, .sys_rst, .k_pos(link.k_pos), .c_pos(link.c_pos),
    .load_strobe_n(link.load_strobe_n), .rd_wr_sel(link.rd_wr_sel),
    .dq_ctrl_oe(link.dq_ctrl_oe), .dq_dev_oe(link.dq_dev_oe),
    .echo_clock(link.echo_clock), .echo_clock_n(link.echo_clock_n));
  always #2.5 sys_clk = ~sys_clk;
  function automatic int word_at(input logic [ADDR_W-1:0] x, input int i);
    return int'({x[17:2], 2'(x[1:0] + i)});
  endfunction
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic request(input logic rd, input logic [ADDR_W-1:0] x);
    req_valid <= 1;
    req_read <= rd;
    req_addr <= x;
    do @(posedge sys_clk); while (req_ready !== 1'b1);
    req_valid <= 0;
    ld_q.push_back({rd, x});
    if (rd) for (int i = 0; i < 4; i++) exp_q.push_back(mem[word_at(x, i)]);
    @(posedge sys_clk);
  endtask
  // valid held across the four words, dropped once per burst
  task automatic fill(input logic [ADDR_W-1:0] x);
    logic [DATA_W-1:0] d;
    for (int i = 0; i < 4; i++) begin
      d = DATA_W'({$urandom, $urandom});
      mem[word_at(x, i)] = d;
      wr_valid <= 1;
      wr_data <= d;
      do @(posedge sys_clk); while (wr_ready !== 1'b1);
    end
    wr_valid <= 0;
    @(posedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    if (!sys_rst && link.load_strobe_n === 1'b0)
      check(DATA_W'({link.rd_wr_sel, link.addr}), DATA_W'(ld_q.size() ? ld_q.pop_front() : 'x));
    if (!sys_rst && rd_valid === 1'b1)
      check(rd_data, exp_q.size() ? exp_q.pop_front() : 'x);
  end
  // roughly sixty times the expected run
  initial begin
    #100us;
    mismatches++;
    report_and_stop();
  end
  initial begin
    void'($urandom(57894));
    base = ADDR_W'($urandom);
    repeat (10) @(posedge sys_clk);
    sys_rst <= 0;
    @(posedge sys_clk);
    for (int s = 0; s < 4; s++) fill({base[17:4], 2'(s), 2'(s)});
    check(DATA_W'(wr_ready), '0);
    for (int s = 0; s < 4; s++) request(0, {base[17:4], 2'(s), 2'(s)});
    for (int s = 0; s < 4; s++) request(1, {base[17:4], 2'(s), 2'(s + 1)});
    repeat (16) @(posedge sys_clk);
    $display("test fill done");
    repeat (30) begin
      single_clock_mode <= 1'($urandom);
      a = {base[17:4], 2'($urandom), 2'($urandom)};
      if ($urandom % 2) request(1, a);
      else begin
        request(0, a);
        fill(a);
      end
    end
    repeat (16) @(posedge sys_clk);
    check(DATA_W'(exp_q.size()), '0);
    $display("test mixed done");
    report_and_stop();
  end
endmodule
`default_nettype wire
